// file: hdl/aaeu_pkg.sv
// Shared constants and types of the add/abs execute unit.
// Assumes a pipeline that decodes instructions and reads both register files.
package aaeu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (APB byte offsets)
    localparam logic [7:0] CTRL_STATUS_OFF = 8'h00;
    localparam logic [7:0] CONFIG_OFF      = 8'h04;
    localparam logic [7:0] IMPL_INFO_OFF   = 8'h08;
    localparam logic [7:0] LAST_EXC_OFF    = 8'h0C;

    // float_ctrl_status field positions
    localparam int RM_LSB      = 0;
    localparam int FLAGS_LSB   = 2;
    localparam int ENABLE_LSB  = 7;
    localparam int CAUSE_LSB   = 12;
    localparam int ABS_2008_CONTROL_BIT = 19;

    // Config field positions and reset values, also those of float_ctrl_status
    localparam int FLOAT_USABLE_BIT = 0;
    localparam int REG_MODEL_BIT    = 1;
    localparam logic FLOAT_USABLE_RST = 1'b1;
    localparam logic REG_MODEL_RST    = 1'b1;
    localparam logic [1:0] RM_RST     = 2'h0;
    localparam logic [4:0] ENABLE_RST = 5'h00;
    localparam logic ABS_2008_CONTROL_RST      = 1'b0;

    // Implementation choices
    localparam logic CAPS_2008_PRESENT = 1'b1;
    localparam logic FPU_64BIT         = 1'b1;
    localparam logic RELEASE6          = 1'b0;

    // Rounding modes
    localparam logic [1:0] RND_NEAREST = 2'h0;
    localparam logic [1:0] RND_ZERO    = 2'h1;
    localparam logic [1:0] RND_UP      = 2'h2;
    localparam logic [1:0] RND_DOWN    = 2'h3;

    // Float formats
    localparam int SGL_EXP_W = 8;
    localparam int SGL_MAN_W = 23;
    localparam int DBL_EXP_W = 11;
    localparam int DBL_MAN_W = 52;

    typedef enum logic [2:0] {
        OP_NONE, OP_FABS, OP_FADD, OP_ADD_TRAP, OP_TRAPPING_IMMEDIATE_SUM_TRAP
    } aaeu_op_e;
    typedef enum logic [1:0] {FMT_S, FMT_D, FMT_PS, FMT_OTHER} aaeu_fmt_e;
    typedef enum logic [2:0] {
        EXC_NONE, EXC_COP_UNUSABLE, EXC_RESERVED, EXC_INT_OVERFLOW,
        EXC_FLOAT
    } aaeu_exc_e;

    typedef struct packed {
        logic        valid;
        aaeu_op_e    op;
        aaeu_fmt_e   fmt;
        logic [4:0]  dest;
        logic [31:0] intSrcA;
        logic [31:0] intSrcB;
        logic [15:0] imm;
        logic [63:0] floatSrcA;
        logic [63:0] floatSrcB;
    } aaeu_issue_s;

    typedef struct packed {
        logic        valid;
        logic        intWrite;
        logic        floatWrite;
        logic [4:0]  dest;
        logic [63:0] data;
        aaeu_exc_e   exc;
    } aaeu_result_s;

endpackage

// file: hdl/aaeu_execute_unit.sv
// Float abs/add lanes and the trapping integer adds, with APB registers.
// Assumes the pipeline holds no instruction back: one issue, one result.
//
// What this block does
// - Float abs writes magnitude of source
// - Paired abs works per half, ORs exceptions
// - Untrapped float op ORs cause into flags
// - Legacy abs mode: any NaN is invalid
// - 2008 abs mode only clears sign bit
// - Paired forms defined only 64-bit, wide model; PS here also runs with regModel_q clear
// - Release 6 lacks paired abs and add
// - Abs raises unusable, reserved, unimplemented, invalid
// - Trapping add sums two 32-bit registers
// - Overflow keeps destination, raises integer overflow
// - No overflow writes sum to destination
// - Overflow when 33-bit sum bits differ
// - Float add rounds per current rounding mode
// - Paired add works per half, ORs exceptions
// - Add raises unimplemented, invalid, inexact, overflow, underflow
// - Immediate add sums 16-bit immediate and register
// - Immediate add writes only without overflow
// - Release 6 lacks trapping immediate add
// - Immediate is sign-extended to word width
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// One float lane: abs or add. Cause order {E,V,Z,O,U,I}.
// Subnormals are not handled here except by 2008 abs; elsewhere they trap as unimplemented,
// and tiny results flush to zero, which keeps the lane small.
module aaeu_float_lane import aaeu_pkg::*;
    #(parameter int EW = 8, parameter int MW = 23) (
    input  wire logic [EW+MW:0] opA,
    input  wire logic [EW+MW:0] opB,
    input  wire logic           absOp,
    input  wire logic           absPlain,
    input  wire logic [1:0]     rndMode,
    output logic      [EW+MW:0] result,
    output logic      [5:0]     cause
);
    localparam int W = MW + 5;
    localparam logic signed [EW+1:0] ONE  = (EW+2)'(1);
    localparam logic signed [EW+1:0] ZERO = (EW+2)'(0);
    localparam logic signed [EW+1:0] EMAX = (EW+2)'((1 << EW) - 1);
    localparam logic [EW+MW:0] QNAN = {1'b0, {EW{1'b1}}, 1'b1,
                                      {(MW-1){1'b0}}};

    logic [EW-1:0]          eA, eB;
    logic                   nanA, nanB, sigA, sigB, infA, infB;
    logic                   zA, zB, dnA, dnB;
    logic                   swap, effSub, sR, inx, rUp, toMax;
    logic [EW+MW:0]         big, lit;
    logic [EW-1:0]          dif;
    logic [W-1:0]           mA, mB, shf, acc;
    logic signed [EW+1:0]   eR;
    logic [MW:0]            frac;
    logic [MW+1:0]          rnd;

    assign eA   = opA[EW+MW-1:MW];
    assign eB   = opB[EW+MW-1:MW];
    assign nanA = (&eA) && (|opA[MW-1:0]);
    assign nanB = (&eB) && (|opB[MW-1:0]);
    assign sigA = nanA && !opA[MW-1];
    assign sigB = nanB && !opB[MW-1];
    assign infA = (&eA) && !(|opA[MW-1:0]);
    assign infB = (&eB) && !(|opB[MW-1:0]);
    assign zA   = (eA == '0) && !(|opA[MW-1:0]);
    assign zB   = (eB == '0) && !(|opB[MW-1:0]);
    assign dnA  = (eA == '0) && (|opA[MW-1:0]);
    assign dnB  = (eB == '0) && (|opB[MW-1:0]);

    // Align, add, normalise, round: exact sum then one rounding
    always_comb begin
        swap   = opB[EW+MW-1:0] > opA[EW+MW-1:0];
        big    = swap ? opB : opA;
        lit    = swap ? opA : opB;
        sR     = big[EW+MW];
        effSub = big[EW+MW] ^ lit[EW+MW];
        dif    = big[EW+MW-1:MW] - lit[EW+MW-1:MW];
        mA     = {2'b01, big[MW-1:0], 3'b000};
        mB     = (lit[EW+MW-1:MW] == '0) ? '0
                                         : {2'b01, lit[MW-1:0], 3'b000};
        shf    = mB >> dif;
        shf[0] = shf[0] | ((shf << dif) != mB);
        acc    = effSub ? mA - shf : mA + shf;
        eR     = $signed({2'b00, big[EW+MW-1:MW]});
        if (acc[W-1]) begin
            acc = {1'b0, acc[W-1:2], acc[1] | acc[0]};
            eR  = eR + ONE;
        end
        for (int i = 0; i < W; i++) begin
            if (!acc[W-2] && acc != '0) begin
                acc = acc << 1;
                eR  = eR - ONE;
            end
        end
        inx = |acc[2:0];
        case (rndMode)
            RND_NEAREST: rUp = acc[2] & (acc[1] | acc[0] | acc[3]);
            RND_UP:      rUp = !sR & inx;
            RND_DOWN:    rUp = sR & inx;
            default:     rUp = 1'b0;
        endcase
        rnd = {1'b0, acc[W-2:3]} + {{(MW+1){1'b0}}, rUp};
        if (rnd[MW+1]) begin
            frac = rnd[MW+1:1];
            eR   = eR + ONE;
        end else begin
            frac = rnd[MW:0];
        end
        toMax = (rndMode == RND_ZERO) || (rndMode == RND_UP && sR) ||
                (rndMode == RND_DOWN && !sR);
    end

    // Special operands first, then the normal path
    always_comb begin
        cause  = '0;
        result = '0;
        if (absOp) begin
            if (absPlain) begin
                result = {1'b0, opA[EW+MW-1:0]};
            end else if (nanA) begin
                result   = QNAN;
                cause[4] = 1'b1;
            end else if (dnA) begin
                cause[5] = 1'b1;
            end else begin
                result = {1'b0, opA[EW+MW-1:0]};
            end
        end else if (dnA || dnB) begin
            cause[5] = 1'b1;
        end else if (nanA || nanB) begin
            result   = QNAN;
            cause[4] = sigA | sigB;
        end else if (infA || infB) begin
            if (infA && infB && (opA[EW+MW] != opB[EW+MW])) begin
                result   = QNAN;
                cause[4] = 1'b1;
            end else begin
                result = infA ? opA : opB;
            end
        end else if (zA && zB) begin
            result[EW+MW] = (opA[EW+MW] & opB[EW+MW]) |
                            ((rndMode == RND_DOWN) &
                             (opA[EW+MW] | opB[EW+MW]));
        end else if (acc == '0) begin
            result[EW+MW] = (rndMode == RND_DOWN);
        end else if (eR >= EMAX) begin
            cause[2] = 1'b1;
            cause[0] = 1'b1;
            result   = toMax ? {sR, {(EW-1){1'b1}}, 1'b0, {MW{1'b1}}}
                             : {sR, {EW{1'b1}}, {MW{1'b0}}};
        end else if (eR <= ZERO) begin
            cause[1]      = 1'b1;
            cause[0]      = 1'b1;
            result[EW+MW] = sR;
        end else begin
            result   = {sR, eR[EW-1:0], frac[MW-1:0]};
            cause[0] = inx;
        end
    end

endmodule // aaeu_float_lane

////////////////////////////////////////////////////////////////////////////
module aaeu_execute_unit import aaeu_pkg::*; (
    input  wire logic          core_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire aaeu_issue_s   issue,
    output aaeu_result_s       result
);
    logic [1:0]         rndMode_q;
    logic [4:0]         flags_q, flags_d, enables_q;
    logic [5:0]         cause_q, cause_d;
    logic               abs_2008_control_q, floatUsable_q, regModel_q;
    aaeu_exc_e          lastExc_q, excD;
    logic [31:0]        prdata_q, rdData;
    logic               pready_q, pslverr_q;
    aaeu_result_s       result_q;
    logic               apbWrite, mapped, ctrlWrite, absPlain, isFloat;
    logic               fpTrap, updateCtrl;
    logic [31:0]        addend;
    logic [32:0]        sum33;
    logic               overflow;
    logic [31:0]        sglRes [2];
    logic [5:0]         sglCause [2];
    logic [63:0]        dblRes, fpuData;
    logic [5:0]         dblCause, fpuCause;

    ////////////////////////////////////////////////////////////////////////
    // Float lanes: two single lanes serve S and both paired halves
    assign absPlain = CAPS_2008_PRESENT & abs_2008_control_q;
    for (genvar g = 0; g < 2; g++) begin : g_sgl
        aaeu_float_lane #(.EW(SGL_EXP_W), .MW(SGL_MAN_W)) u_lane (
            .opA     (issue.floatSrcA[32*g +: 32]),
            .opB     (issue.floatSrcB[32*g +: 32]),
            .absOp   (issue.op == OP_FABS),
            .absPlain(absPlain),
            .rndMode (rndMode_q),
            .result  (sglRes[g]),
            .cause   (sglCause[g])
        );
    end
    aaeu_float_lane #(.EW(DBL_EXP_W), .MW(DBL_MAN_W)) u_dbl (
        .opA     (issue.floatSrcA),
        .opB     (issue.floatSrcB),
        .absOp   (issue.op == OP_FABS),
        .absPlain(absPlain),
        .rndMode (rndMode_q),
        .result  (dblRes),
        .cause   (dblCause)
    );

    // Paired halves run on their own lanes; results are still produced
    // with the narrow register model, software must not rely on them.
    always_comb begin
        case (issue.fmt)
            FMT_D: begin
                fpuData  = dblRes;
                fpuCause = dblCause;
            end
            FMT_PS: begin
                fpuData  = {sglRes[1], sglRes[0]};
                fpuCause = sglCause[0] | sglCause[1];
            end
            default: begin
                fpuData  = {32'h00000000, sglRes[0]};
                fpuCause = sglCause[0];
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Trapping adds
    assign addend = (issue.op == OP_TRAPPING_IMMEDIATE_SUM_TRAP)
                  ? {{16{issue.imm[15]}}, issue.imm}
                  : issue.intSrcB;
    assign sum33 = {issue.intSrcA[31], issue.intSrcA} +
                   {addend[31], addend};
    assign overflow = sum33[32] ^ sum33[31];

    // Unimplemented operation always traps; others follow the enables
    assign isFloat = (issue.op == OP_FABS) || (issue.op == OP_FADD);
    assign fpTrap  = |(fpuCause & {1'b1, enables_q});

    always_comb begin
        excD = EXC_NONE;
        if (!issue.valid) begin
            excD = EXC_NONE;
        end else if (isFloat && !floatUsable_q) begin
            excD = EXC_COP_UNUSABLE;
        end else if (isFloat && (issue.fmt == FMT_OTHER ||
                     (issue.fmt == FMT_PS && RELEASE6))) begin
            excD = EXC_RESERVED;
        end else if (issue.op == OP_TRAPPING_IMMEDIATE_SUM_TRAP && RELEASE6) begin
            excD = EXC_RESERVED;
        end else if (issue.op == OP_NONE) begin
            excD = EXC_RESERVED;
        end else if (!isFloat && overflow) begin
            excD = EXC_INT_OVERFLOW;
        end else if (isFloat && fpTrap) begin
            excD = EXC_FLOAT;
        end
    end

    // Result to the pipeline; any exception blocks the register write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_q <= '0;
        end else begin
            result_q.valid      <= issue.valid;
            result_q.intWrite   <= issue.valid && !isFloat &&
                                   excD == EXC_NONE;
            result_q.floatWrite <= issue.valid && isFloat &&
                                   excD == EXC_NONE;
            result_q.dest       <= issue.dest;
            result_q.data       <= isFloat ? fpuData
                                           : {32'h00000000, sum33[31:0]};
            result_q.exc        <= excD;
        end
    end
    assign result = result_q;

    ////////////////////////////////////////////////////////////////////////
    // Control and status; hardware updates win over a software write
    assign apbWrite  = psel && penable && pready_q && pwrite;
    assign ctrlWrite = apbWrite && paddr == CTRL_STATUS_OFF;
    assign updateCtrl = issue.valid && isFloat && !(issue.op == OP_FABS &&
                        absPlain) && (excD == EXC_NONE || excD == EXC_FLOAT);

    always_comb begin
        flags_d = ctrlWrite ? pwdata[FLAGS_LSB +: 5] : flags_q;
        cause_d = ctrlWrite ? pwdata[CAUSE_LSB +: 6] : cause_q;
        if (updateCtrl) begin
            cause_d = fpuCause;
        end
        if (updateCtrl && excD == EXC_NONE) begin
            flags_d = flags_d | fpuCause[4:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flags_q <= 5'h00;
            cause_q <= 6'h00;
        end else begin
            flags_q <= flags_d;
            cause_q <= cause_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rndMode_q     <= RM_RST;
            enables_q     <= ENABLE_RST;
            abs_2008_control_q     <= ABS_2008_CONTROL_RST;
            floatUsable_q <= FLOAT_USABLE_RST;
            regModel_q    <= REG_MODEL_RST;
        end else if (ctrlWrite) begin
            rndMode_q <= pwdata[RM_LSB +: 2];
            enables_q <= pwdata[ENABLE_LSB +: 5];
            abs_2008_control_q <= pwdata[ABS_2008_CONTROL_BIT] & CAPS_2008_PRESENT;
        end else if (apbWrite && paddr == CONFIG_OFF) begin
            floatUsable_q <= pwdata[FLOAT_USABLE_BIT];
            regModel_q    <= pwdata[REG_MODEL_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            lastExc_q <= EXC_NONE;
        end else if (excD != EXC_NONE) begin
            lastExc_q <= excD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB slave: read data captured in setup, ready in the access cycle
    always_comb begin
        rdData = 32'h00000000;
        mapped = 1'b1;
        case (paddr)
            CTRL_STATUS_OFF: begin
                rdData[RM_LSB +: 2]     = rndMode_q;
                rdData[FLAGS_LSB +: 5]  = flags_q;
                rdData[ENABLE_LSB +: 5] = enables_q;
                rdData[CAUSE_LSB +: 6]  = cause_q;
                rdData[ABS_2008_CONTROL_BIT]     = abs_2008_control_q;
            end
            CONFIG_OFF: begin
                rdData[FLOAT_USABLE_BIT] = floatUsable_q;
                rdData[REG_MODEL_BIT]    = regModel_q;
            end
            IMPL_INFO_OFF: begin
                rdData[3:0] = {RELEASE6, !RELEASE6, FPU_64BIT,
                               CAPS_2008_PRESENT};
            end
            LAST_EXC_OFF: rdData[2:0] = lastExc_q;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            pready_q  <= 1'b1;
            prdata_q  <= pwrite ? 32'h00000000 : rdData;
            pslverr_q <= !mapped;
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end
    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_ovfNoWrite;
        issue.valid && issue.op == OP_ADD_TRAP && floatUsable_q && overflow
        |=> result.exc == EXC_INT_OVERFLOW && !result.intWrite;
    endproperty
    a_ovfNoWrite: assert property (p_ovfNoWrite)
        else $error("overflowing add wrote its destination");

    property p_addSum;
        issue.valid && issue.op == OP_ADD_TRAP && !overflow
        |=> result.intWrite &&
            result.data[31:0] == $past(issue.intSrcA + issue.intSrcB);
    endproperty
    a_addSum: assert property (p_addSum)
        else $error("register add result wrong");

    property p_immSum;
        issue.valid && issue.op == OP_TRAPPING_IMMEDIATE_SUM_TRAP && !RELEASE6 && !overflow
        |=> result.intWrite && result.data[31:0] == $past(issue.intSrcA +
            {{16{issue.imm[15]}}, issue.imm});
    endproperty
    a_immSum: assert property (p_immSum)
        else $error("immediate add result wrong");

    property p_ovfDetect;
        issue.valid && !isFloat && issue.op != OP_NONE && !RELEASE6 ##1
        !result.floatWrite |-> (result.exc == EXC_INT_OVERFLOW) ==
        ($past(sum33[32]) != $past(sum33[31]));
    endproperty
    a_ovfDetect: assert property (p_ovfDetect)
        else $error("overflow detection mismatch");

    property p_excNoWrite;
        result.valid && result.exc != EXC_NONE
        |-> !result.intWrite && !result.floatWrite;
    endproperty
    a_excNoWrite: assert property (p_excNoWrite)
        else $error("writeback alongside an exception");

    property p_absPlain;
        issue.valid && issue.op == OP_FABS && issue.fmt == FMT_D &&
        absPlain && floatUsable_q
        |=> result.floatWrite && result.data ==
            {1'b0, $past(issue.floatSrcA[62:0])} && $stable(cause_q);
    endproperty
    a_absPlain: assert property (p_absPlain)
        else $error("2008 abs changed more than the sign");

    property p_flagsSticky;
        !ctrlWrite |=> (flags_q & $past(flags_q)) == $past(flags_q);
    endproperty
    a_flagsSticky: assert property (p_flagsSticky)
        else $error("flag bit lost without a write");

    property p_unusable;
        issue.valid && isFloat && !floatUsable_q
        |=> result.exc == EXC_COP_UNUSABLE && !result.floatWrite;
    endproperty
    a_unusable: assert property (p_unusable)
        else $error("float op ran while unusable");

endmodule // aaeu_execute_unit

// file: tb/aaeu_pipe_model.sv
// Pipeline stand-in: hands one decoded instruction to the execute unit.
// Assumes send is called just after a rising edge of core_clk.
`timescale 1ns/1ps
module aaeu_pipe_model import aaeu_pkg::*; (
    input  wire logic   core_clk,
    output aaeu_issue_s issue
);
    initial issue = '0;

    // Held for exactly one taken edge, then withdrawn
    task automatic send(input aaeu_issue_s i);
        aaeu_issue_s z;
        issue <= i;
        @(posedge core_clk);
        // Idle word scrambled so stale operands are never reused by luck
        z = ~i;
        z.valid = 1'b0;
        issue <= z;
    endtask
endmodule // aaeu_pipe_model

// file: tb/tb.sv
// Self-checking bench: reference arithmetic for the integer adds, fixed expected values for the float ops, compared with every result.
// Assumes the package, the unit and the pipeline stand-in compile first.
`timescale 1ns/1ps
module tb import aaeu_pkg::*;;
    logic         core_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd, seed, a, b;
    aaeu_issue_s  issue;
    aaeu_result_s result;
    int           mismatches = 0, comparisons = 0, cycles = 0;
    logic [31:0]  ea [4] = '{32'h7FFFFFFF, 32'h80000000, 32'hFFFFFFFF,
                             32'h00000000};
    logic [31:0]  eb [4] = '{32'h00000001, 32'hFFFFFFFF, 32'hFFFFFFFF,
                             32'h80000000};
    logic [31:0]  rnd [4] = '{32'h3F800000, 32'h3F800000, 32'h3F800001,
                              32'h3F800000};

    aaeu_execute_unit dut_u (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .issue(issue),
        .result(result));
    aaeu_pipe_model pipe_u (.core_clk(core_clk), .issue(issue));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    // Run needs a few hundred cycles; the ceiling leaves ample slack
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic aaeu_result_s iadd(logic [31:0] x, y);
        logic [32:0] s;
        s = {x[31], x} + {y[31], y};
        iadd = '0;
        if (s[32] != s[31]) iadd.exc = EXC_INT_OVERFLOW;
        else begin
            iadd.intWrite = 1;
            iadd.data = {32'h00000000, s[31:0]};
        end
    endfunction
    function automatic aaeu_result_s fres(logic [63:0] d);
        fres = '0;
        fres.floatWrite = 1;
        fres.data = d;
    endfunction
    function automatic aaeu_result_s xres(aaeu_exc_e x);
        xres = '0;
        xres.exc = x;
    endfunction

    task automatic chk(string n, logic [79:0] s, logic [79:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // One APB transfer; no wait count is assumed, only a bound
    task automatic apb(logic w, logic [7:0] ad, logic [31:0] d, logic e);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        // Only the bench timeout ends a wait that never sees pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        chk("pready", pready, 1);
        chk("pslverr", pslverr, e);
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic rdchk(logic [7:0] ad, logic [31:0] e);
        apb(0, ad, 0, 0);
        chk("prdata", rd, e);
    endtask

    // Issue one op; dc masks data a rule leaves open
    task automatic run(aaeu_op_e op, aaeu_fmt_e f, logic [63:0] x, y,
                       logic [15:0] im, aaeu_result_s e, logic dc);
        aaeu_issue_s i;
        seed = lfsr(seed);
        i = '{1'b1, op, f, seed[4:0], x[31:0], y[31:0], im, x, y};
        pipe_u.send(i);
        @(posedge core_clk);
        e.valid = 1;
        e.dest = i.dest;
        if (dc || e.exc != EXC_NONE) begin
            e.data = result.data;
        end else if (!e.floatWrite) e.data[63:32] = result.data[63:32];
        chk("result", result, e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata} = '1;
        {psel, penable} = 2'h0;
        seed = 32'h000110E2;
        repeat (4) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        rdchk(CTRL_STATUS_OFF, 32'h00000000);
        rdchk(CONFIG_OFF, 32'h00000003);
        apb(0, 8'h10, 32'h00000000, 1);
        for (int k = 0; k < 40; k++) begin
            seed = lfsr(seed);
            a = (k < 4) ? ea[k] : seed;
            seed = lfsr(seed);
            b = (k < 4) ? eb[k] : seed;
            run(OP_ADD_TRAP, FMT_S, a, b, 0, iadd(a, b),
                0);
            run(OP_TRAPPING_IMMEDIATE_SUM_TRAP, FMT_S, a, ~b, b[15:0],
                iadd(a, {{16{b[15]}}, b[15:0]}),
                0);
        end
        run(OP_FABS, FMT_S, 64'hFFC00000, 0, 0, fres(64'h7FC00000),
            0);
        rdchk(CTRL_STATUS_OFF, 32'h00010040);
        apb(1, CTRL_STATUS_OFF, 32'h00090040, 0);
        run(OP_FABS, FMT_S, 64'hFFC00000, 0, 0, fres(64'h7FC00000),
            0);
        run(OP_FABS, FMT_S, 64'hC0000000, 0, 0, fres(64'h40000000),
            0);
        run(OP_FABS, FMT_PS, 64'hC0000000BF800000, 0, 0,
            fres(64'h400000003F800000), 0);
        run(OP_FABS, FMT_D, 64'hC000000000000000, 0, 0,
            fres(64'h4000000000000000), 0);
        rdchk(CTRL_STATUS_OFF, 32'h00090040);
        run(OP_FADD, FMT_S, 64'h3F800000, 64'h3F800000, 0,
            fres(64'h40000000), 0);
        run(OP_FADD, FMT_PS, 64'h3F80000040000000, 64'h3F80000040000000, 0,
            fres(64'h4000000040800000), 0);
        run(OP_FADD, FMT_D, 64'h3FF0000000000000, 64'h3FF0000000000000, 0,
            fres(64'h4000000000000000), 0);
        rdchk(CTRL_STATUS_OFF, 32'h00080040);
        run(OP_FADD, FMT_S, 64'h7F7FFFFF, 64'h7F7FFFFF, 0,
            fres(64'h7F800000), 0);
        rdchk(CTRL_STATUS_OFF, 32'h00085054);
        for (int m = 0; m < 4; m++) begin
            apb(1, CTRL_STATUS_OFF, 32'h00080000 | m, 0);
            run(OP_FADD, FMT_S, 64'h3F800000, 64'h33800000, 0,
                fres({32'h00000000, rnd[m]}), 0);
        end
        rdchk(CTRL_STATUS_OFF, 32'h00081007);
        // Enabled invalid makes the legacy abs trap: cause kept, no flags
        apb(1, CTRL_STATUS_OFF, 32'h00000800, 0);
        run(OP_FABS, FMT_S, 64'hFFC00000, 0, 0, xres(EXC_FLOAT), 1);
        rdchk(CTRL_STATUS_OFF, 32'h00010800);
        apb(1, CONFIG_OFF, 32'h00000002, 0);
        run(OP_FABS, FMT_S, 0, 0, 0, xres(EXC_COP_UNUSABLE), 1);
        apb(1, CONFIG_OFF, 32'h00000003, 0);
        run(OP_NONE, FMT_S, 0, 0, 0, xres(EXC_RESERVED), 1);
        run(OP_FABS, FMT_OTHER, 0, 0, 0, xres(EXC_RESERVED), 1);
        run(OP_FABS, FMT_S, 64'h00000001, 0, 0, xres(EXC_FLOAT), 1);
        run(OP_FADD, FMT_D, 64'h7FF0000000000001, 0, 0,
            xres(EXC_FLOAT), 1);
        rdchk(LAST_EXC_OFF, 32'(EXC_FLOAT));
        rdchk(IMPL_INFO_OFF, {28'h0000000, RELEASE6, !RELEASE6, FPU_64BIT,
                              CAPS_2008_PRESENT});
        summarize();
    end
endmodule // tb
